/* File: src/hold_buffer.sv */
// Write block holding registers, preset to erased value
`timescale 1ns/1ps
`default_nettype none
module hold_buffer
    import tblnvm_pkg::*;
#(
    parameter int unsigned IDX_W = 7
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // Byte write from the table latch
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire logic [7:0]       wr_data,
    // Preset after a block is programmed
    input  wire logic             preset,
    // Read port toward the flash programmer
    input  wire logic [IDX_W-1:0] rd_idx,
    output logic      [7:0]       rd_data
);
    localparam int unsigned DEPTH = 1 << IDX_W;

    logic [7:0] mem_r   [DEPTH];
    logic [7:0] mem_nxt [DEPTH];

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            if (preset) begin
                mem_nxt[i] = HOLD_RST;
            end else if (wr_en && (wr_idx == IDX_W'(i))) begin
                mem_nxt[i] = wr_data;
            end else begin
                mem_nxt[i] = mem_r[i];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= HOLD_RST;
            end
        end else begin
            mem_r <= mem_nxt;
        end
    end

    assign rd_data = mem_r[rd_idx];
endmodule // hold_buffer
`default_nettype wire

/* File: src/tblnvm_access.sv */
// Table pointer, transfer latch, holding buffer and NVM unlock control
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Upper, high and low pointer bytes form one 22-bit byte address.
// [R2] Bits 0-20 address program space; bit 21 selects ID and configuration.
// [R3] Auto increment and decrement change bits 0-20 only, never bit 21.
// [R4] Modifiers: none, post-increment, post-decrement, pre-increment.
// [R5] An 8-bit latch receives read bytes and supplies written bytes.
// [R6] A table read fetches the byte at the full pointer into the latch.
// [R7] A table write stores the latch into the holding byte at low pointer bits.
// [R8] Holding buffer of 128 bytes, indexed by pointer bits 6-0, size parameterised.
// [R9] Block programming targets the upper pointer bits, low bits ignored.
// [R10] A read stalls the core; latch is valid in the following cycle.
// [R11] Pointer bit 0 picks the high or low byte of a 16-bit word.
// [R12] Table operations are byte granular with no alignment demands.
// [R13] Erase and writes start only after a completed unlock sequence.
// [R14] Software writes 55h, then AAh, then sets the write-start bit.
// [R15] Unlock steps must be consecutive; only an unbroken sequence is accepted.
// [R16] While the write-start bit is set the core stays stalled.
// [R17] Software masks interrupts around the unlock sequence.
// [R18] An interrupt or debug halt during the sequence cancels the action.
// [R19] Completion clears write-start and sets the done flag, raising interrupt if enabled.
// [R20] Start on a reserved or protected address sets write error, changes nothing.
module tblnvm_access
    import tblnvm_pkg::*;
#(
    parameter int unsigned HOLD_IDX_W = 7
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // Special function register writes from the core
    input  wire logic              sfr_wr_en,
    input  wire logic [2:0]        sfr_sel,
    input  wire logic [7:0]        sfr_wdata,
    // Register contents seen by the core
    output logic      [PTR_W-1:0]  table_byte_pointer,
    output logic      [7:0]        table_transfer_latch,
    output logic      [7:0]        nvm_control_register,
    output logic                   nvm_done_flag,
    output logic                   nvm_done_irq_enable,
    output logic                   nvm_irq,
    // Table instructions from the core
    input  wire logic              tbl_req,
    input  wire logic              tbl_is_write,
    input  wire logic [1:0]        tbl_mod,
    output logic                   cpu_stall,
    // Sequence disturbance from the core
    input  wire logic              irq_taken,
    input  wire logic              debug_halt,
    // Write protection lookup for the current pointer
    input  wire logic              wr_protect_hit,
    // Program memory word read
    output logic                   flash_rd_req,
    output logic      [PTR_W-2:0]  flash_rd_word_addr,
    input  wire logic              flash_rd_ack,
    input  wire logic [15:0]       flash_rd_word,
    // Long operation toward the flash programmer
    output logic                   nvm_cmd_start,
    output logic                   nvm_cmd_erase,
    output logic      [1:0]        nvm_cmd_region,
    output logic      [PTR_W-1:0]  nvm_cmd_addr,
    input  wire logic              nvm_cmd_done,
    input  wire logic [HOLD_IDX_W-1:0] hold_rd_idx,
    output logic      [7:0]        hold_rd_data
);
    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_TWRITE, ST_LONG} state_t;
    typedef enum logic [1:0] {KEY_NONE, KEY_GOT1, KEY_GOT2} key_t;

    state_t           state_r, state_nxt;
    key_t             key_r, key_nxt;
    logic [PTR_W-1:0] ptr_r, ptr_nxt;
    logic [7:0]       latch_r, latch_nxt;
    logic [7:0]       ctrl_r, ctrl_nxt;
    logic             done_r, done_nxt;
    logic             ien_r, ien_nxt;
    logic [1:0]       mod_r, mod_nxt;
    logic             start_r, start_nxt;
    logic             hold_we, hold_preset;
    logic             region_ok, wr_set_req;

    function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p, input logic dec);
        logic [PTR_INC_TOP:0] low;
        low = dec ? p[PTR_INC_TOP:0] - 1'b1 : p[PTR_INC_TOP:0] + 1'b1;
        return {p[REGION_BIT], low}; // [R3]
    endfunction

    function automatic logic [PTR_W-1:0] post_mod(input logic [PTR_W-1:0] p, input logic [1:0] m);
        case (m)
            MOD_POST_INC: return step(p, 1'b0);
            MOD_POST_DEC: return step(p, 1'b1);
            default:      return p;
        endcase
    endfunction

    // Valid target for the selected memory; EEPROM addressing lives elsewhere
    always_comb begin
        if (ctrl_r[CTRL_REG_LSB+1 -: 2] == REG_PFM) begin
            region_ok = !ptr_r[REGION_BIT] && (ptr_r <= PFM_END) && !wr_protect_hit; // [R2] [R20]
        end else if (ctrl_r[CTRL_REG_LSB]) begin
            region_ok = ((ptr_r >= UID_START) && (ptr_r <= UID_END))
                     || ((ptr_r >= CFG_START) && (ptr_r <= CFG_END));
        end else begin
            region_ok = (ctrl_r[CTRL_REG_LSB+1 -: 2] == REG_EEPROM);
        end
    end

    assign wr_set_req = sfr_wr_en && (sfr_sel == SEL_CTRL) && sfr_wdata[CTRL_WR_BIT];

    always_comb begin
        state_nxt   = state_r;
        key_nxt     = key_r;
        ptr_nxt     = ptr_r;
        latch_nxt   = latch_r;
        ctrl_nxt    = ctrl_r;
        done_nxt    = done_r;
        ien_nxt     = ien_r;
        mod_nxt     = mod_r;
        start_nxt   = 1'b0;
        hold_we     = 1'b0;
        hold_preset = 1'b0;
        case (state_r)
            ST_IDLE: begin
                // Any access other than the next unlock step breaks the sequence
                if (irq_taken || debug_halt || tbl_req) begin
                    key_nxt = KEY_NONE; // [R15] [R18]
                end else if (sfr_wr_en) begin
                    if (sfr_sel == SEL_KEY && sfr_wdata == KEY_FIRST && key_r == KEY_NONE) begin
                        key_nxt = KEY_GOT1; // [R14]
                    end else if (sfr_sel == SEL_KEY && sfr_wdata == KEY_SECOND
                                 && key_r == KEY_GOT1) begin
                        key_nxt = KEY_GOT2; // [R14]
                    end else begin
                        key_nxt = KEY_NONE; // [R15]
                    end
                end
                if (tbl_req) begin
                    mod_nxt   = tbl_mod;
                    if (tbl_mod == MOD_PRE_INC) begin
                        ptr_nxt = step(ptr_r, 1'b0); // [R4]
                    end
                    state_nxt = tbl_is_write ? ST_TWRITE : ST_READ;
                end else if (sfr_wr_en) begin
                    case (sfr_sel)
                        SEL_PTR_UPPER: ptr_nxt[21:16] = sfr_wdata[5:0]; // [R1]
                        SEL_PTR_HIGH:  ptr_nxt[15:8]  = sfr_wdata;      // [R1]
                        SEL_PTR_LOW:   ptr_nxt[7:0]   = sfr_wdata;      // [R1]
                        SEL_LATCH:     latch_nxt      = sfr_wdata;      // [R5]
                        SEL_IRQ: begin
                            done_nxt = sfr_wdata[IRQ_DONE_BIT];
                            ien_nxt  = sfr_wdata[IRQ_EN_BIT];
                        end
                        SEL_CTRL: begin
                            // Write-start is set-only; error bit may be cleared by software
                            ctrl_nxt = {sfr_wdata[7:6], 1'b0, sfr_wdata[CTRL_FREE_BIT],
                                        sfr_wdata[CTRL_WRITE_ERROR_FLAG_BIT], sfr_wdata[CTRL_WREN_BIT],
                                        1'b0, 1'b0};
                            if (wr_set_req && key_r == KEY_GOT2
                                && !irq_taken && !debug_halt
                                && sfr_wdata[CTRL_WREN_BIT]) begin // [R13] [R15] [R18]
                                if (region_ok) begin
                                    ctrl_nxt[CTRL_WR_BIT] = 1'b1;
                                    start_nxt = 1'b1;
                                    state_nxt = ST_LONG; // [R16]
                                end else begin
                                    ctrl_nxt[CTRL_WRITE_ERROR_FLAG_BIT] = 1'b1; // [R20]
                                end
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ST_READ: begin
                if (flash_rd_ack) begin
                    latch_nxt = ptr_r[0] ? flash_rd_word[15:8] : flash_rd_word[7:0]; // [R6] [R11]
                    ptr_nxt   = post_mod(ptr_r, mod_r); // [R4]
                    state_nxt = ST_IDLE; // [R10]
                end
            end
            ST_TWRITE: begin
                hold_we   = 1'b1; // [R7]
                ptr_nxt   = post_mod(ptr_r, mod_r); // [R4] [R12]
                state_nxt = ST_IDLE;
            end
            ST_LONG: begin
                if (nvm_cmd_done) begin
                    ctrl_nxt[CTRL_WR_BIT] = 1'b0; // [R19]
                    done_nxt    = 1'b1; // [R19]
                    hold_preset = !ctrl_r[CTRL_FREE_BIT];
                    state_nxt   = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            key_r   <= KEY_NONE;
            ptr_r   <= PTR_RST;
            latch_r <= LATCH_RST;
            ctrl_r  <= 8'h00;
            done_r  <= 1'b0;
            ien_r   <= 1'b0;
            mod_r   <= MOD_NONE;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            key_r   <= key_nxt;
            ptr_r   <= ptr_nxt;
            latch_r <= latch_nxt;
            ctrl_r  <= ctrl_nxt;
            done_r  <= done_nxt;
            ien_r   <= ien_nxt;
            mod_r   <= mod_nxt;
            start_r <= start_nxt;
        end
    end

    hold_buffer #(
        .IDX_W   (HOLD_IDX_W)
    ) u_hold (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .wr_en   (hold_we),
        .wr_idx  (ptr_r[HOLD_IDX_W-1:0]), // [R7] [R8]
        .wr_data (latch_r),
        .preset  (hold_preset),
        .rd_idx  (hold_rd_idx),
        .rd_data (hold_rd_data)
    );

    assign table_byte_pointer   = ptr_r;
    assign table_transfer_latch = latch_r;
    assign nvm_control_register = ctrl_r;
    assign nvm_done_flag        = done_r;
    assign nvm_done_irq_enable  = ien_r;
    assign nvm_irq              = done_r && ien_r; // [R19]
    assign cpu_stall            = (state_r != ST_IDLE); // [R10] [R16]
    assign flash_rd_req         = (state_r == ST_READ);
    assign flash_rd_word_addr   = ptr_r[PTR_W-1:1]; // [R11]
    assign nvm_cmd_start        = start_r;
    assign nvm_cmd_erase        = ctrl_r[CTRL_FREE_BIT];
    assign nvm_cmd_region       = ctrl_r[CTRL_REG_LSB+1 -: 2];
    // Block base only: low bits are dropped for programming and erase
    assign nvm_cmd_addr = {ptr_r[PTR_W-1:HOLD_IDX_W], {HOLD_IDX_W{1'b0}}}; // [R9]

    bit21_kept_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R3]
        (state_r != ST_IDLE) |=> ptr_r[REGION_BIT] == $past(ptr_r[REGION_BIT]))
        else $error("pointer bit 21 changed by a table modifier");

    start_needs_key_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R13]
        $rose(ctrl_r[CTRL_WR_BIT]) |-> $past(key_r) == KEY_GOT2 && $past(wr_set_req))
        else $error("write-start set without a complete unlock");

    cmd_follows_wr_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R16]
        nvm_cmd_start |-> ctrl_r[CTRL_WR_BIT] && cpu_stall)
        else $error("command issued without write-start and stall");

    err_no_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R20]
        $rose(ctrl_r[CTRL_WRITE_ERROR_FLAG_BIT]) && $past(state_r) == ST_IDLE && $past(wr_set_req)
        |-> !nvm_cmd_start && !ctrl_r[CTRL_WR_BIT])
        else $error("write error raised yet the operation started");

    read_latch_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
        (state_r == ST_READ && flash_rd_ack) |=>
        latch_r == ($past(ptr_r[0]) ? $past(flash_rd_word[15:8]) : $past(flash_rd_word[7:0]))
        && !cpu_stall)
        else $error("read byte not in latch on the following cycle");

    done_clears_wr_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R19]
        (state_r == ST_LONG && nvm_cmd_done) |=> !ctrl_r[CTRL_WR_BIT] && done_r && !cpu_stall)
        else $error("completion did not clear write-start and set done");

    stall_while_wr_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R16]
        ctrl_r[CTRL_WR_BIT] |-> cpu_stall)
        else $error("core not stalled during long operation");

    halt_breaks_key_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R18]
        (irq_taken || debug_halt) && state_r == ST_IDLE |=> key_r == KEY_NONE
        && !ctrl_r[CTRL_WR_BIT])
        else $error("disturbed sequence still armed");

    post_inc_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R4]
        state_r == ST_TWRITE && mod_r == MOD_POST_INC |=>
        ptr_r[PTR_INC_TOP:0] == $past(ptr_r[PTR_INC_TOP:0]) + 21'h000001)
        else $error("post-increment did not advance the pointer");
endmodule // tblnvm_access
`default_nettype wire

/* File: src/tblnvm_pkg.sv */
// Constants shared by the table pointer and NVM access block
package tblnvm_pkg;
    localparam int unsigned PTR_W       = 22;
    localparam int unsigned PTR_INC_TOP = 20;
    localparam int unsigned REGION_BIT  = 21;

    // Register select codes on the special function register port
    localparam logic [2:0] SEL_PTR_UPPER = 3'h0;
    localparam logic [2:0] SEL_PTR_HIGH  = 3'h1;
    localparam logic [2:0] SEL_PTR_LOW   = 3'h2;
    localparam logic [2:0] SEL_LATCH     = 3'h3;
    localparam logic [2:0] SEL_KEY       = 3'h4;
    localparam logic [2:0] SEL_CTRL      = 3'h5;
    localparam logic [2:0] SEL_IRQ       = 3'h6;

    // Control register fields
    localparam int unsigned CTRL_WR_BIT    = 1;
    localparam int unsigned CTRL_WREN_BIT  = 2;
    localparam int unsigned CTRL_WRITE_ERROR_FLAG_BIT = 3;
    localparam int unsigned CTRL_FREE_BIT  = 4;
    localparam int unsigned CTRL_REG_LSB   = 6;
    localparam logic [1:0]  REG_EEPROM     = 2'h0;
    localparam logic [1:0]  REG_PFM        = 2'h2;

    // Interrupt register fields
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_EN_BIT   = 1;

    // Unlock keys
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // Region bounds on the byte pointer
    localparam logic [21:0] PFM_END    = 22'h01ffff;
    localparam logic [21:0] UID_START  = 22'h200000;
    localparam logic [21:0] UID_END    = 22'h20000f;
    localparam logic [21:0] CFG_START  = 22'h300000;
    localparam logic [21:0] CFG_END    = 22'h30000b;

    // Values after reset
    localparam logic [21:0] PTR_RST   = 22'h000000;
    localparam logic [7:0]  LATCH_RST = 8'h00;
    localparam logic [7:0]  HOLD_RST  = 8'hff;

    // Pointer modifiers of a table operation
    localparam logic [1:0] MOD_NONE     = 2'h0;
    localparam logic [1:0] MOD_POST_INC = 2'h1;
    localparam logic [1:0] MOD_POST_DEC = 2'h2;
    localparam logic [1:0] MOD_PRE_INC  = 2'h3;
endpackage

/* File: test/flash_side_model.sv */
// Behavioural flash array and programmer facing the table access block
`timescale 1ns/1ps
`default_nettype none
module flash_side_model
    import tblnvm_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Answer pace: low is prompt, high is slow
    input  wire logic        slow,
    // Program memory word read
    input  wire logic        flash_rd_req,
    input  wire logic [20:0] flash_rd_word_addr,
    output logic             flash_rd_ack,
    output logic      [15:0] flash_rd_word,
    // Long operation
    input  wire logic        nvm_cmd_start,
    output logic             nvm_cmd_done
);
    logic [3:0] rd_cnt_r;
    logic [3:0] pg_cnt_r;
    logic       pg_busy_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_cnt_r      <= 4'h0;
            pg_cnt_r      <= 4'h0;
            pg_busy_r     <= 1'b0;
            flash_rd_ack  <= 1'b0;
            flash_rd_word <= 16'h0000;
            nvm_cmd_done  <= 1'b0;
        end else begin
            flash_rd_ack  <= 1'b0;
            nvm_cmd_done  <= 1'b0;
            // Word lines are not held outside the answer cycle
            flash_rd_word <= ~flash_rd_word;
            if (flash_rd_req && !flash_rd_ack) begin
                if (rd_cnt_r == (slow ? 4'h6 : 4'h1)) begin
                    flash_rd_ack  <= 1'b1;
                    flash_rd_word <= {flash_rd_word_addr[7:0] ^ 8'h5a, flash_rd_word_addr[7:0]};
                    rd_cnt_r      <= 4'h0;
                end else begin
                    rd_cnt_r <= rd_cnt_r + 4'h1;
                end
            end
            if (nvm_cmd_start) begin
                pg_busy_r <= 1'b1;
                pg_cnt_r  <= 4'h0;
            end else if (pg_busy_r) begin
                pg_cnt_r <= pg_cnt_r + 4'h1;
                if (pg_cnt_r == (slow ? 4'h9 : 4'h2)) begin
                    nvm_cmd_done <= 1'b1;
                    pg_busy_r    <= 1'b0;
                end
            end
        end
    end
endmodule // flash_side_model
`default_nettype wire

/* File: test/tblnvm_access_tb.sv */
// Self-checking bench for the table pointer and NVM unlock block
`timescale 1ns/1ps
`default_nettype none
module tblnvm_access_tb
    import tblnvm_pkg::*;
;
    logic sys_clk, sys_rst, sfr_wr_en, tbl_req, tbl_is_write, irq_taken, debug_halt;
    logic wr_protect_hit, slow, flash_rd_req, flash_rd_ack, cpu_stall;
    logic nvm_done_flag, nvm_done_irq_enable, nvm_irq, nvm_cmd_start, nvm_cmd_erase, nvm_cmd_done;
    logic [2:0]  sfr_sel;
    logic [7:0]  sfr_wdata, table_transfer_latch, nvm_control_register, hold_rd_data;
    logic [1:0]  tbl_mod, nvm_cmd_region;
    logic [21:0] table_byte_pointer, nvm_cmd_addr;
    logic [20:0] flash_rd_word_addr;
    logic [15:0] flash_rd_word;
    logic [6:0]  hold_rd_idx;
    int          err_total, n_compared;

    tblnvm_access DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_wr_en(sfr_wr_en),
        .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata), .table_byte_pointer(table_byte_pointer),
        .table_transfer_latch(table_transfer_latch), .nvm_control_register(nvm_control_register),
        .nvm_done_flag(nvm_done_flag), .nvm_done_irq_enable(nvm_done_irq_enable),
        .nvm_irq(nvm_irq), .tbl_req(tbl_req), .tbl_is_write(tbl_is_write), .tbl_mod(tbl_mod),
        .cpu_stall(cpu_stall), .irq_taken(irq_taken), .debug_halt(debug_halt),
        .wr_protect_hit(wr_protect_hit), .flash_rd_req(flash_rd_req),
        .flash_rd_word_addr(flash_rd_word_addr), .flash_rd_ack(flash_rd_ack),
        .flash_rd_word(flash_rd_word), .nvm_cmd_start(nvm_cmd_start),
        .nvm_cmd_erase(nvm_cmd_erase), .nvm_cmd_region(nvm_cmd_region),
        .nvm_cmd_addr(nvm_cmd_addr), .nvm_cmd_done(nvm_cmd_done),
        .hold_rd_idx(hold_rd_idx), .hold_rd_data(hold_rd_data));

    flash_side_model far_side (.sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow),
        .flash_rd_req(flash_rd_req), .flash_rd_word_addr(flash_rd_word_addr),
        .flash_rd_ack(flash_rd_ack), .flash_rd_word(flash_rd_word),
        .nvm_cmd_start(nvm_cmd_start), .nvm_cmd_done(nvm_cmd_done));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [21:0] got, input logic [21:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_val({21'h0, got}, {21'h0, exp}, what);
    endtask

    task automatic sfr_wr(input logic [2:0] sel, input logic [7:0] data);
        @(negedge sys_clk);
        sfr_wr_en = 1'b1;
        sfr_sel   = sel;
        sfr_wdata = data;
        @(negedge sys_clk);
        sfr_wr_en = 1'b0;
    endtask

    task automatic set_ptr(input logic [21:0] p);
        sfr_wr(SEL_PTR_UPPER, {2'b00, p[21:16]});
        sfr_wr(SEL_PTR_HIGH, p[15:8]);
        sfr_wr(SEL_PTR_LOW, p[7:0]);
    endtask

    task automatic wait_idle();
        int i;
        i = 0;
        while (cpu_stall !== 1'b0 && i < 60) begin
            @(negedge sys_clk);
            i++;
        end
        chk_bit(cpu_stall, 1'b0, "stall released");
    endtask

    task automatic tbl_op(input logic wr, input logic [1:0] m);
        @(negedge sys_clk);
        tbl_req      = 1'b1;
        tbl_is_write = wr;
        tbl_mod      = m;
        @(negedge sys_clk);
        tbl_req = 1'b0;
        wait_idle();
    endtask

    // Core side of the long write: interrupts stay masked, so a disturbance is deliberate
    task automatic unlock(input logic [7:0] ctrl, input int brk);
        sfr_wr(SEL_KEY, KEY_FIRST);
        @(negedge sys_clk);
        irq_taken  = (brk == 1);
        debug_halt = (brk == 2);
        @(negedge sys_clk);
        irq_taken  = 1'b0;
        debug_halt = 1'b0;
        if (brk == 3) sfr_wr(SEL_PTR_LOW, table_byte_pointer[7:0]);
        sfr_wr(SEL_KEY, KEY_SECOND);
        sfr_wr(SEL_CTRL, ctrl);
    endtask

    function automatic logic [7:0] exp_byte(input logic [21:0] p);
        return p[0] ? (p[8:1] ^ 8'h5a) : p[8:1];
    endfunction

    function automatic logic [21:0] step(input logic [21:0] p, input logic up);
        return {p[21], up ? p[20:0] + 21'h1 : p[20:0] - 21'h1};
    endfunction

    task automatic t_reset();
        hold_rd_idx = 7'h00;
        @(negedge sys_clk);
        chk_val(table_byte_pointer, PTR_RST, "pointer after reset");
        chk_val(table_transfer_latch, LATCH_RST, "latch after reset");
        chk_val(nvm_control_register, 22'h0, "control after reset");
        chk_val(hold_rd_data, HOLD_RST, "holding after reset");
    endtask

    task automatic t_read_modes();
        logic [21:0] base, a, ep;
        for (int k = 0; k < 8; k++) begin
            base = (k < 4) ? 22'h3fffff : 22'h000000;
            slow = k[0];
            set_ptr(base);
            tbl_op(1'b0, k[1:0]);
            a  = (k[1:0] == MOD_PRE_INC) ? step(base, 1'b1) : base;
            ep = (k[1:0] == MOD_NONE) ? base : step(base, k[1:0] != MOD_POST_DEC);
            chk_val(table_transfer_latch, exp_byte(a), "read byte");
            chk_val(table_byte_pointer, ep, "pointer after read");
        end
    endtask

    task automatic t_write();
        set_ptr(22'h3c1285);
        sfr_wr(SEL_LATCH, 8'h3c);
        tbl_op(1'b1, MOD_POST_INC);
        hold_rd_idx = 7'h05;
        #1 chk_val(hold_rd_data, 8'h3c, "holding byte written");
        hold_rd_idx = 7'h06;
        #1 chk_val(hold_rd_data, HOLD_RST, "neighbour untouched");
        chk_val(table_byte_pointer, 22'h3c1286, "pointer after write");
    endtask

    task automatic t_program();
        sfr_wr(SEL_IRQ, 8'h02);
        chk_bit(nvm_done_irq_enable, 1'b1, "done enable");
        set_ptr(22'h001285);
        slow = 1'b1;
        unlock(8'h86, 0);
        chk_bit(nvm_cmd_start, 1'b1, "program start");
        chk_bit(cpu_stall, 1'b1, "stall on long write");
        chk_val(nvm_cmd_addr, 22'h001280, "block address");
        chk_val(nvm_cmd_region, REG_PFM, "region");
        chk_bit(nvm_cmd_erase, 1'b0, "program not erase");
        wait_idle();
        chk_bit(nvm_control_register[CTRL_WR_BIT], 1'b0, "start bit cleared");
        chk_bit(nvm_done_flag, 1'b1, "done flag");
        chk_bit(nvm_irq, 1'b1, "done interrupt");
        hold_rd_idx = 7'h05;
        #1 chk_val(hold_rd_data, HOLD_RST, "holding preset");
        sfr_wr(SEL_IRQ, 8'h00);
        chk_bit(nvm_irq, 1'b0, "interrupt cleared");
    endtask

    // Erase leaves the holding bytes alone, unlike a block program
    task automatic t_erase();
        set_ptr(22'h001285);
        sfr_wr(SEL_LATCH, 8'h77);
        tbl_op(1'b1, MOD_NONE);
        chk_val(table_byte_pointer, 22'h001285, "pointer unmodified");
        unlock(8'h96, 0);
        chk_bit(nvm_cmd_start, 1'b1, "erase start");
        chk_bit(nvm_cmd_erase, 1'b1, "erase select");
        wait_idle();
        chk_bit(nvm_done_flag, 1'b1, "erase done flag");
        hold_rd_idx = 7'h05;
        #1 chk_val(hold_rd_data, 8'h77, "holding kept by erase");
        sfr_wr(SEL_IRQ, 8'h00);
    endtask

    task automatic t_broken();
        for (int k = 1; k <= 3; k++) begin
            unlock(8'h86, k);
            chk_bit(nvm_cmd_start, 1'b0, "broken unlock start");
            chk_bit(nvm_control_register[CTRL_WR_BIT], 1'b0, "broken unlock bit");
            chk_bit(cpu_stall, 1'b0, "broken unlock stall");
        end
    endtask

    task automatic t_refused();
        for (int j = 0; j < 3; j++) begin
            set_ptr(j == 0 ? 22'h020000 : (j == 1 ? 22'h001285 : 22'h200010));
            sfr_wr(SEL_CTRL, j == 2 ? 8'h44 : 8'h84);
            chk_bit(nvm_control_register[CTRL_WRITE_ERROR_FLAG_BIT], 1'b0, "error cleared");
            wr_protect_hit = (j == 1);
            unlock(j == 2 ? 8'h46 : 8'h86, 0);
            chk_bit(nvm_control_register[CTRL_WRITE_ERROR_FLAG_BIT], 1'b1, "write error");
            chk_bit(nvm_cmd_start, 1'b0, "refused start");
            chk_bit(nvm_control_register[CTRL_WR_BIT], 1'b0, "refused bit");
            wr_protect_hit = 1'b0;
        end
    endtask

    // Whole run is a few hundred cycles; the limit leaves ample margin
    initial begin
        #200000;
        err_total++;
        $display("MISMATCH %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        err_total = 0; n_compared = 0; sys_rst = 1'b1; sfr_wr_en = 1'b0; sfr_sel = 3'h0;
        sfr_wdata = 8'h00; tbl_req = 1'b0; tbl_is_write = 1'b0; tbl_mod = 2'h0;
        irq_taken = 1'b0; debug_halt = 1'b0; wr_protect_hit = 1'b0; slow = 1'b0;
        hold_rd_idx = 7'h00;
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_reset();
        t_read_modes();
        t_write();
        t_program();
        t_erase();
        t_broken();
        t_refused();
        complete_run();
    end
endmodule // tblnvm_access_tb
`default_nettype wire
